//--- rtl/spisc_pkg.sv
// Purpose: constants and types for the serial port control and status block
// Assumes: 32-bit classic Wishbone, byte lane 0 carries the 8-bit registers
// Notes: shared by the design and the bench
package spisc_pkg;
   // register byte addresses
   localparam logic [7:0] CFG_ADDR = 8'hf4;
   localparam logic [7:0] CTRL_ADDR = 8'hf8;
   localparam logic [7:0] DATA_ADDR = 8'hfc;
   // control register field positions
   localparam int DONE_BIT = 7;
   localparam int WRITE_COLLISION_FLAG_BIT = 6;
   localparam int MODE_FAULT_FLAG_BIT = 5;
   localparam int OVR_BIT = 4;
   localparam int MODE_HI_BIT = 3;
   localparam int MODE_LO_BIT = 2;
   localparam int TXE_BIT = 1;
   localparam int EN_BIT = 0;
   // config register field positions
   localparam int MASTER_ENABLE_BIT = 0;
   // values after reset
   localparam logic [7:0] CTRL_RESET = 8'h06;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // select mode encodings
   localparam logic [1:0] MODE_3WIRE = 2'h0;
   localparam logic [1:0] MODE_4WIRE_IN = 2'h1;
   // master clock timing
   localparam int MCLK_PERIOD_NS = 50;
   localparam int SCK_HALF_NS = 200;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam logic [7:0] SCK_HALF_LAST = 8'(SCK_HALF_CYC - 1);
   localparam logic [2:0] LAST_BIT = 3'h7;
   typedef enum logic [1:0] {
      SPISC_IDLE = 2'b00,
      SPISC_LOW = 2'b01,
      SPISC_HIGH = 2'b10
   } spisc_mst_t;
endpackage : spisc_pkg

//--- rtl/spisc_top.sv
// Purpose: control and status flags of a serial peripheral port with transfer engines
// Assumes: clock phase 0, polarity 0; link clock SCK_IN comes from the far master
// Notes: slave logic runs on SCK_IN, everything else on MCLK
//
// Notes on behaviour
// RULE1 - transfer done flag sets at end of each byte; only software clears it
// RULE2 - set transfer done flag raises the port interrupt line
// RULE3 - data write during a transfer sets write collision flag and interrupt
// RULE4 - select low, master enabled, mode 01 sets mode fault flag and interrupt
// RULE5 - slave byte ending with unread receive data sets overrun flag and interrupt
// RULE6 - mode 00 is three-wire; select pin is not used at all
// RULE7 - mode 01 (reset default) treats the select pin as input only
// RULE8 - mode 1x drives the select pin with the low mode bit
// RULE9 - writing the transmit buffer clears the buffer empty flag
// RULE10 - moving the buffer into the shifter sets the buffer empty flag
// RULE11 - port enable bit switches the whole port on and off
`timescale 1ns/1ps
module spisc_top (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic SCK_IN,
   output logic SCK_OUT,
   output logic SCK_OE,
   input wire logic MOSI_IN,
   output logic MOSI_OUT,
   output logic MOSI_OE,
   input wire logic MISO_IN,
   output logic MISO_OUT,
   output logic MISO_OE,
   input wire logic NSS_IN,
   output logic NSS_OUT,
   output logic NSS_OE,
   output logic IRQ
);
   logic rst_q1, rst_q2, rst_n;
   logic nss_q1, nss_q2, miso_q1, miso_q2;
   logic ack_q1, ack_q2, ack_q3, done_q1, done_q2, done_q3;
   logic transfer_done_flag, write_collision_flag, mode_fault_flag, receive_overrun_flag;
   logic [1:0] select_mode_field;
   logic tx_buffer_empty, port_enable, master_enable;
   logic [7:0] tx_buf, rx_buf;
   logic rx_full, slv_busy, req_tgl;
   spisc_pkg::spisc_mst_t mst_state;
   logic [7:0] mst_div, mst_sh;
   logic [2:0] mst_bit;
   logic mst_load, mst_done, mst_busy;
   logic wb_req, wr_ctrl, wr_data, wr_cfg, rd_data;
   logic [7:0] rd_val;
   logic slv_done, slv_moved, busy, data_accept;
   logic [1:0] cfg_l1, cfg_l2;
   logic req_l1, req_l2, ack_tgl, done_tgl, link_act;
   logic [2:0] bit_l;
   logic [7:0] sh_i, sh_o, rx_l;

   // reset release through two flops
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end
   assign rst_n = rst_q2;

   // pin and link-event synchronisers
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         nss_q1 <= 1'b1;
         nss_q2 <= 1'b1;
         miso_q1 <= 1'b0;
         miso_q2 <= 1'b0;
         ack_q1 <= 1'b0;
         ack_q2 <= 1'b0;
         ack_q3 <= 1'b0;
         done_q1 <= 1'b0;
         done_q2 <= 1'b0;
         done_q3 <= 1'b0;
      end else begin
         nss_q1 <= NSS_IN;
         nss_q2 <= nss_q1;
         miso_q1 <= MISO_IN;
         miso_q2 <= miso_q1;
         ack_q1 <= ack_tgl;
         ack_q2 <= ack_q1;
         ack_q3 <= ack_q2;
         done_q1 <= done_tgl;
         done_q2 <= done_q1;
         done_q3 <= done_q2;
      end
   end
   assign slv_done = (done_q2 != done_q3) && !master_enable;
   assign slv_moved = (ack_q2 != ack_q3) && !master_enable;

   // bus decode
   assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   always_comb begin
      wr_ctrl = 1'b0;
      wr_data = 1'b0;
      wr_cfg = 1'b0;
      rd_data = 1'b0;
      rd_val = 8'h00;
      if (wb_req && WB_ADR_I == spisc_pkg::CTRL_ADDR) begin
         wr_ctrl = WB_WE_I && WB_SEL_I[0];
         rd_val = {transfer_done_flag, write_collision_flag, mode_fault_flag,
                   receive_overrun_flag, select_mode_field, tx_buffer_empty, port_enable};
      end else if (wb_req && WB_ADR_I == spisc_pkg::DATA_ADDR) begin
         wr_data = WB_WE_I && WB_SEL_I[0];
         rd_data = !WB_WE_I;
         rd_val = rx_buf;
      end else if (wb_req && WB_ADR_I == spisc_pkg::CFG_ADDR) begin
         wr_cfg = WB_WE_I && WB_SEL_I[0];
         rd_val = {7'h00, master_enable};
      end
   end
   assign mst_busy = mst_state != spisc_pkg::SPISC_IDLE;
   assign busy = mst_busy || slv_busy;
   assign data_accept = wr_data && !busy;

   // single-cycle ack; unmapped addresses ack and read zero
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= wb_req;
         WB_DAT_O <= {24'h00_0000, rd_val};
      end
   end

   // writable control fields
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         select_mode_field <= spisc_pkg::CTRL_RESET[spisc_pkg::MODE_HI_BIT:spisc_pkg::MODE_LO_BIT];
         port_enable <= spisc_pkg::CTRL_RESET[spisc_pkg::EN_BIT];
         master_enable <= spisc_pkg::CFG_RESET[spisc_pkg::MASTER_ENABLE_BIT];
      end else begin
         if (wr_ctrl) begin
            select_mode_field <= WB_DAT_I[spisc_pkg::MODE_HI_BIT:spisc_pkg::MODE_LO_BIT];
            port_enable <= WB_DAT_I[spisc_pkg::EN_BIT]; // RULE11
         end
         if (wr_cfg) begin
            master_enable <= WB_DAT_I[spisc_pkg::MASTER_ENABLE_BIT];
         end
      end
   end

   // sticky flags: a hardware set beats a software write in the same cycle
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         transfer_done_flag <= spisc_pkg::CTRL_RESET[spisc_pkg::DONE_BIT];
         write_collision_flag <= spisc_pkg::CTRL_RESET[spisc_pkg::WRITE_COLLISION_FLAG_BIT];
         mode_fault_flag <= spisc_pkg::CTRL_RESET[spisc_pkg::MODE_FAULT_FLAG_BIT];
         receive_overrun_flag <= spisc_pkg::CTRL_RESET[spisc_pkg::OVR_BIT];
      end else begin
         if (mst_done || slv_done) begin
            transfer_done_flag <= 1'b1; // RULE1
         end else if (wr_ctrl) begin
            transfer_done_flag <= WB_DAT_I[spisc_pkg::DONE_BIT];
         end
         if (wr_data && busy) begin
            write_collision_flag <= 1'b1; // RULE3
         end else if (wr_ctrl) begin
            write_collision_flag <= WB_DAT_I[spisc_pkg::WRITE_COLLISION_FLAG_BIT];
         end
         if (port_enable && !nss_q2 && master_enable
             && select_mode_field == spisc_pkg::MODE_4WIRE_IN) begin
            mode_fault_flag <= 1'b1; // RULE4
         end else if (wr_ctrl) begin
            mode_fault_flag <= WB_DAT_I[spisc_pkg::MODE_FAULT_FLAG_BIT];
         end
         if (slv_done && rx_full) begin
            receive_overrun_flag <= 1'b1; // RULE5
         end else if (wr_ctrl) begin
            receive_overrun_flag <= WB_DAT_I[spisc_pkg::OVR_BIT];
         end
      end
   end

   // interrupt line follows the flags; enabling is the core's business
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= transfer_done_flag || write_collision_flag
                || mode_fault_flag || receive_overrun_flag; // RULE2
      end
   end

   // transmit buffer; a write loses to nothing, since a late move is stale anyway
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         tx_buf <= 8'h00;
         tx_buffer_empty <= spisc_pkg::CTRL_RESET[spisc_pkg::TXE_BIT];
         req_tgl <= 1'b0;
      end else begin
         if (data_accept) begin
            tx_buf <= WB_DAT_I[7:0];
            tx_buffer_empty <= 1'b0; // RULE9
            req_tgl <= master_enable ? req_tgl : ~req_tgl;
         end else if (mst_load || slv_moved) begin
            tx_buffer_empty <= 1'b1; // RULE10
         end
      end
   end

   // receive buffer and slave busy tracking
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         rx_buf <= 8'h00;
         rx_full <= 1'b0;
         slv_busy <= 1'b0;
      end else begin
         if (mst_done) begin
            // last bit enters the shifter on this same edge, so take it from the pin copy
            rx_buf <= {mst_sh[6:0], miso_q2};
            rx_full <= 1'b1;
         end else if (slv_done) begin
            rx_buf <= rx_l;
            rx_full <= 1'b1;
         end else if (rd_data) begin
            rx_full <= 1'b0;
         end
         if (slv_moved) begin
            slv_busy <= 1'b1;
         end else if (slv_done || !port_enable) begin
            slv_busy <= 1'b0;
         end
      end
   end

   // master engine: eight bits, data out before the rising edge
   assign mst_load = mst_state == spisc_pkg::SPISC_IDLE && port_enable && master_enable
                     && !tx_buffer_empty && !mode_fault_flag;
   assign mst_done = mst_state == spisc_pkg::SPISC_HIGH && mst_div == spisc_pkg::SCK_HALF_LAST
                     && mst_bit == spisc_pkg::LAST_BIT;
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         mst_state <= spisc_pkg::SPISC_IDLE;
         mst_div <= 8'h00;
         mst_bit <= 3'h0;
         mst_sh <= 8'h00;
      end else begin
         case (mst_state)
            spisc_pkg::SPISC_IDLE: begin
               mst_div <= 8'h00;
               mst_bit <= 3'h0;
               if (mst_load) begin
                  mst_sh <= tx_buf; // RULE10
                  mst_state <= spisc_pkg::SPISC_LOW;
               end
            end
            spisc_pkg::SPISC_LOW: begin
               mst_div <= mst_div + 8'h01;
               if (!port_enable) begin
                  mst_state <= spisc_pkg::SPISC_IDLE; // RULE11
               end else if (mst_div == spisc_pkg::SCK_HALF_LAST) begin
                  mst_div <= 8'h00;
                  mst_state <= spisc_pkg::SPISC_HIGH;
               end
            end
            spisc_pkg::SPISC_HIGH: begin
               mst_div <= mst_div + 8'h01;
               if (!port_enable) begin
                  mst_state <= spisc_pkg::SPISC_IDLE;
               end else if (mst_div == spisc_pkg::SCK_HALF_LAST) begin
                  // sample late in the high half so the synchroniser lag is absorbed
                  mst_div <= 8'h00;
                  mst_sh <= {mst_sh[6:0], miso_q2};
                  mst_bit <= mst_bit + 3'h1;
                  mst_state <= (mst_bit == spisc_pkg::LAST_BIT) ? spisc_pkg::SPISC_IDLE
                                                                : spisc_pkg::SPISC_LOW;
               end
            end
            default: mst_state <= spisc_pkg::SPISC_IDLE;
         endcase
      end
   end

   // pin drivers
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         SCK_OUT <= 1'b0;
         SCK_OE <= 1'b0;
         MOSI_OUT <= 1'b0;
         MOSI_OE <= 1'b0;
         MISO_OE <= 1'b0;
         NSS_OUT <= 1'b1;
         NSS_OE <= 1'b0;
      end else begin
         SCK_OUT <= mst_state == spisc_pkg::SPISC_HIGH;
         SCK_OE <= port_enable && master_enable; // RULE11
         MOSI_OUT <= mst_sh[7];
         MOSI_OE <= port_enable && master_enable;
         MISO_OE <= port_enable && !master_enable
                    && (select_mode_field == spisc_pkg::MODE_3WIRE || !nss_q2); // RULE6
         NSS_OUT <= select_mode_field[0]; // RULE8
         NSS_OE <= port_enable && select_mode_field[1]; // RULE7
      end
   end

   // link domain: config levels crossed by two flops; frames must be byte aligned
   assign link_act = cfg_l2[1] && (cfg_l2[0] || !NSS_IN); // RULE6
   always_ff @(posedge SCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         cfg_l1 <= 2'h0;
         cfg_l2 <= 2'h0;
         req_l1 <= 1'b0;
         req_l2 <= 1'b0;
      end else begin
         cfg_l1 <= {port_enable && !master_enable, select_mode_field == spisc_pkg::MODE_3WIRE};
         cfg_l2 <= cfg_l1;
         req_l1 <= req_tgl;
         req_l2 <= req_l1;
      end
   end

   // next byte is staged at the last edge, so the very first frame sends zeros
   always_ff @(posedge SCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         bit_l <= 3'h0;
         sh_i <= 8'h00;
         sh_o <= 8'h00;
         rx_l <= 8'h00;
         ack_tgl <= 1'b0;
         done_tgl <= 1'b0;
      end else if (link_act) begin
         bit_l <= bit_l + 3'h1;
         sh_i <= {sh_i[6:0], MOSI_IN};
         sh_o <= {sh_o[6:0], 1'b0};
         if (bit_l == spisc_pkg::LAST_BIT) begin
            rx_l <= {sh_i[6:0], MOSI_IN};
            done_tgl <= ~done_tgl; // RULE5
            if (req_l2 != ack_tgl) begin
               sh_o <= tx_buf;
               ack_tgl <= ~ack_tgl; // RULE10
            end
         end
      end
   end

   always_ff @(negedge SCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         MISO_OUT <= 1'b0;
      end else if (link_act) begin
         MISO_OUT <= sh_o[7];
      end
   end

   // checks
   sequence s_master_start;
      mst_state == spisc_pkg::SPISC_IDLE && mst_load;
   endsequence
   sequence s_collide;
      wr_data && busy;
   endsequence

   chk_done_sticky: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE1
      transfer_done_flag && !wr_ctrl |=> transfer_done_flag)
      else $error("transfer done flag dropped without software");
   chk_master_frame: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE1
      s_master_start ##1 port_enable [*8] |-> ##[56:60] transfer_done_flag)
      else $error("master byte did not set transfer done");
   chk_irq_follow: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE2
      (mst_done || slv_done) |=> ##1 IRQ)
      else $error("interrupt line not raised after byte");
   chk_write_collision_flag_set: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE3
      s_collide |=> write_collision_flag && $stable(tx_buf))
      else $error("write collision not flagged or buffer overwritten");
   chk_mode_fault_flag_set: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE4
      port_enable && master_enable && !nss_q2 && select_mode_field == 2'h1
      |=> mode_fault_flag ##1 IRQ)
      else $error("mode fault not flagged");
   chk_ovr_set: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE5
      slv_done && rx_full |=> receive_overrun_flag)
      else $error("overrun not flagged");
   chk_nss_input: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE7
      !select_mode_field[1] |=> !NSS_OE)
      else $error("select pin driven in input mode");
   chk_nss_output: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE8
      port_enable && select_mode_field[1] |=> NSS_OE && NSS_OUT == $past(select_mode_field[0]))
      else $error("select pin not driven with low mode bit");
   chk_txe_clear: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE9
      data_accept |=> !tx_buffer_empty)
      else $error("buffer empty flag not cleared by write");
   chk_txe_set: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE10
      s_master_start |=> tx_buffer_empty && mst_state == spisc_pkg::SPISC_LOW)
      else $error("buffer empty not set when loaded");
   chk_port_off: assert property (@(posedge MCLK) disable iff (!rst_n) // RULE11
      !port_enable |=> !SCK_OE && !MOSI_OE && !MISO_OE && !NSS_OE)
      else $error("pins driven while port disabled");
endmodule : spisc_top

//--- verification/spisc_peer.sv
// Purpose: far-side serial device, slave when the port masters, master otherwise
// Assumes: clock phase 0, polarity 0
// Notes: link clock only toggles inside frame calls, four deselected pre-pulses then the selected byte
`timescale 1ns/1ps
module spisc_peer (
   output logic sck,
   output logic mosi,
   output logic nss_n,
   output logic miso,
   input wire logic sck_out,
   input wire logic mosi_out,
   input wire logic miso_out,
   input wire logic nss_out,
   input wire logic nss_oe
);
   logic [7:0] shift_in = 8'h00;
   logic [7:0] miso_byte = 8'h00;
   logic [7:0] last = 8'h00;
   int cnt = 0;
   wire sel = nss_oe && !nss_out;
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      nss_n = 1'b1;
      miso = 1'b0;
   end
   // slave role: sample on rising, shift out on falling
   always @(posedge sck_out) begin
      if (sel) begin
         shift_in = {shift_in[6:0], mosi_out};
         cnt = cnt + 1;
         if (cnt == 8) begin
            last = shift_in;
            cnt = 0;
         end
      end
   end
   always @(negedge sck_out) begin
      if (sel) begin
         miso_byte = miso_byte << 1;
         miso = miso_byte[7];
      end
   end
   // released line must not look held
   always @(posedge nss_out) miso = ~miso;
   task automatic arm(input logic [7:0] b);
      miso_byte = b;
      miso = b[7];
   endtask : arm
   // master role; deselected pre-pulses let config levels cross
   task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
      repeat (4) begin
         #15 sck = 1'b1;
         #15 sck = 1'b0;
      end
      #7 nss_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         #15 sck = 1'b1;
         rx[i] = miso_out;
         #15 sck = 1'b0;
      end
      #15 nss_n = 1'b1;
      mosi = ~mosi;
   endtask : frame
endmodule : spisc_peer

//--- verification/tb_spi_control_status_flags.sv
// Purpose: self-checking bench for the serial port control and status block
// Assumes: one-cycle Wishbone answer; peer model plays the far side
// Notes: flags polled over the bus, every wait bounded
`timescale 1ns/1ps
module tb_spi_control_status_flags;
   localparam logic [7:0] ctl = spisc_pkg::CTRL_ADDR;
   localparam logic [7:0] cfg = spisc_pkg::CFG_ADDR;
   localparam logic [7:0] dta = spisc_pkg::DATA_ADDR;
   logic MCLK = 1'b0;
   logic NRST = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat;
   logic ack, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, nss_o, nss_oe, irq;
   logic sck_i, mosi_i, nss_i, miso_i;
   int failures = 0;
   int tests_run = 0;
   logic [7:0] q, d, r, t;
   logic [7:0] exp_q[$];
   always #25 MCLK = ~MCLK;
   spisc_top u_dut (.MCLK(MCLK), .NRST(NRST), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .SCK_IN(sck_i), .SCK_OUT(sck_o), .SCK_OE(sck_oe), .MOSI_IN(mosi_i),
      .MOSI_OUT(mosi_o), .MOSI_OE(mosi_oe), .MISO_IN(miso_i), .MISO_OUT(miso_o),
      .MISO_OE(miso_oe), .NSS_IN(nss_i), .NSS_OUT(nss_o), .NSS_OE(nss_oe), .IRQ(irq));
   spisc_peer u_peer (.sck(sck_i), .mosi(mosi_i), .nss_n(nss_i), .miso(miso_i),
      .sck_out(sck_o), .mosi_out(mosi_o), .miso_out(miso_o), .nss_out(nss_o),
      .nss_oe(nss_oe));
   task automatic final_report();
      if (failures == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] got, input logic [7:0] e, input string m);
      tests_run++;
      if (got !== e) begin
         failures++;
         $display("[FAIL] %0t %s got %h expected %h", $time, m, got, e);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v,
         output logic [7:0] o);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      dat <= {24'h0, v};
      do begin
         @(posedge MCLK);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk(8'h00, 8'h01, "no bus answer");
         final_report();
      end
      o = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge MCLK);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      wb(1'b1, a, v, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
      wb(1'b0, a, 8'h00, q);
      chk(q, e, m);
   endtask : rd
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         wb(1'b0, ctl, 8'h00, q);
         n++;
      end while (q[7] !== 1'b1 && n < 100);
      if (n >= 100) chk(8'h00, 8'h01, "transfer never ended");
   endtask : wait_done
   initial begin
      #5ms;
      chk(8'h00, 8'h01, "run too long");
      final_report();
   end
   initial begin
      r = 8'($urandom(32'h37b6));
      repeat (5) @(posedge MCLK);
      NRST <= 1'b1;
      repeat (3) @(posedge MCLK);
      rd(ctl, spisc_pkg::CTRL_RESET, "control reset value");
      rd(cfg, spisc_pkg::CFG_RESET, "config reset value");
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00, "unmapped read");
      for (int m = 0; m < 4; m++) begin
         wr(ctl, {4'h0, 2'(m), 2'b01});
         chk({7'h0, nss_oe}, {7'h0, m[1]}, "select pin direction");
         if (m > 1) chk({7'h0, nss_o}, {7'h0, m[0]}, "select pin level");
         rd(ctl, {4'h0, 2'(m), 2'b11}, "mode readback");
      end
      // port off: no select drive and no transfer
      wr(ctl, 8'h0c);
      chk({7'h0, nss_oe}, 8'h00, "select driven while off");
      wr(cfg, 8'h01);
      d = 8'($urandom);
      wr(dta, d);
      repeat (80) @(posedge MCLK);
      wb(1'b0, ctl, 8'h00, q);
      chk({7'h0, q[7]}, 8'h00, "transfer while off");
      // master byte with a collision in mid-transfer
      wr(ctl, 8'h09);
      t = 8'($urandom);
      u_peer.arm(t);
      exp_q.push_back(d);
      exp_q.push_back(t);
      wr(dta, d);
      wr(dta, ~d);
      wait_done();
      rd(ctl, 8'hcb, "flags after master byte");
      chk({7'h0, irq}, 8'h01, "interrupt line");
      chk(u_peer.last, exp_q.pop_front(), "byte seen by peer");
      rd(dta, exp_q.pop_front(), "byte from peer");
      repeat (20) @(posedge MCLK);
      rd(ctl, 8'hcb, "done flag held");
      wr(ctl, 8'h09);
      chk({7'h0, irq}, 8'h00, "interrupt after clear");
      // select low while mastering in mode 01
      wr(ctl, 8'h05);
      u_peer.nss_n <= 1'b0;
      repeat (6) @(posedge MCLK);
      rd(ctl, 8'h27, "mode fault");
      chk({7'h0, irq}, 8'h01, "fault interrupt");
      u_peer.nss_n <= 1'b1;
      wr(cfg, 8'h00);
      wr(ctl, 8'h05);
      rd(ctl, 8'h07, "fault cleared");
      // slave frames: staging, readout, overrun
      wb(1'b0, dta, 8'h00, q);
      t = 8'($urandom);
      wr(dta, t);
      rd(ctl, 8'h05, "buffer full after write");
      for (int k = 0; k < 3; k++) begin
         d = 8'($urandom);
         u_peer.frame(d, r);
         repeat (10) @(posedge MCLK);
         rd(ctl, {3'b100, 1'(k == 2), 4'h7}, "slave flags");
         if (k == 1) chk(r, t, "slave sent byte");
         if (k == 0) begin
            exp_q.push_back(d);
            rd(dta, exp_q.pop_front(), "slave received byte");
         end
         wr(ctl, 8'h05);
      end
      final_report();
   end
endmodule : tb_spi_control_status_flags
